// ==== osfc_pkg.sv ====
// Shared constants and types for the octal switch serial frame block
package osfc_pkg;

  localparam int unsigned CH_COUNT     = 8;
  localparam int unsigned SHORT_BITS   = 8;
  localparam int unsigned LONG_BITS    = 16;
  localparam int unsigned CHECK_BITS   = 8;
  localparam int unsigned SHIFT_WIDTH  = 24;
  localparam int unsigned COUNT_WIDTH  = 5;
  localparam int unsigned CRC_WIDTH    = 7;
  localparam int unsigned CRC_IN_WIDTH = 17;
  localparam int unsigned LINK_SYNC_W  = 9;
  localparam int unsigned STAT_SYNC_W  = 33;

  localparam logic [6:0] CRC_INIT      = 7'h7f;
  localparam logic [6:0] CRC_POLY      = 7'h37;
  localparam logic [7:0] CFG_RESET     = 8'h00;
  localparam logic [7:0] SETTING_RESET = 8'h00;
  localparam logic [4:0] LEN_SHORT     = 5'h08;
  localparam logic [4:0] LEN_LONG      = 5'h10;
  localparam logic [4:0] LEN_CHECK     = 5'h08;
  localparam logic [4:0] COUNT_MAX     = 5'h1f;

  typedef enum logic [1:0] {
    FR_SET8,
    FR_CFG8,
    FR_SETCFG16,
    FR_CFG16
  } osfc_frame_type;

endpackage

// ==== osfc_sync.sv ====
// Three-stage input synchroniser; a change passes once stages two and three agree
module osfc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_core_clk, // Core clock
  input  wire logic         i_rst_n,    // Asynchronous reset, active low
  input  wire logic         i_clk_en,   // Freezes all state while low
  input  wire logic [W-1:0] i_async,    // Inputs from outside the clock domain
  output logic      [W-1:0] o_level     // Filtered levels
);

  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] held;
  } osfc_sync_type;

  osfc_sync_type state;
  osfc_sync_type next_state;

  // Stage one is read only by stage two
  for (genvar b = 0; b < W; b++) begin : g_bit
    assign o_level[b] = (state.ff2[b] == state.ff3[b]) ? state.ff3[b] : state.held[b];
  end

  always_comb begin
    next_state      = state;
    next_state.ff1  = i_async;
    next_state.ff2  = state.ff1;
    next_state.ff3  = state.ff2;
    next_state.held = o_level;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= '0;
    end else if (i_clk_en) begin
      state <= next_state;
    end
  end

endmodule

// ==== osfc_crc7.sv ====
// Seven-bit frame check over 9 or 17 bits, first bit at the top
module osfc_crc7 (
  input  wire logic [16:0] i_bits, // Bits right-justified, oldest bit first
  input  wire logic        i_long, // High for 17 bits, low for 9
  output logic      [6:0]  o_crc   // Resulting check bits
);

  always_comb begin
    logic [6:0] acc;
    logic       fb;
    acc = osfc_pkg::CRC_INIT;
    fb  = 1'b0;
    for (int i = osfc_pkg::CRC_IN_WIDTH - 1; i >= 0; i--) begin
      if (i_long || (i <= osfc_pkg::SHORT_BITS)) begin
        fb  = i_bits[i] ^ acc[6];
        acc = {acc[5:0], 1'b0} ^ (fb ? osfc_pkg::CRC_POLY : 7'h00);
      end
    end
    o_crc = acc;
  end

endmodule

// ==== osfc_core.sv ====
// Serial frame control core of the eight-channel output switch
// Contract
// - Serial, short, config frame: 8 bits, mode bits in, fault flags out.
// - Serial, long, no config select: setting byte and mode byte in; faults, levels out.
// - Parallel or long config frame: two config bits per channel; faults, levels out.
// - Setting 0 drives low or off, 1 drives high or on.
// - Short config frame: mode bit 0 high-side, 1 push-pull.
// - Global push-pull force makes every channel push-pull.
// - Long config code 00 hs, 01/11 push-pull, 10 hs with open-load.
// - Open-load only on high-side; global enable covers all high-side channels in serial.
// - Short fault flag: overload/thermal, overtemp, or open load while off.
// - Undervoltage lockout reports all eight short fault flags as one.
// - Level bit one above threshold, zero below, undefined under fault.
// - Long diagnostics pairs: 00 low, 01 high, 10 fault, 11 undervoltage.
// - Check enabled in serial mode: verify inbound byte, append outbound byte.
// - Seven-bit check, polynomial x7+x5+x4+x2+x+1, start value 7f.
// - Check mismatch discards frame and raises the error pin at once.
// - Mismatch sets the error flag in the next frame's outbound check byte.
// - Outbound check covers diagnostics plus the error flag.
// - Data output is released whenever chip select is high.
// - Mode 0: capture at select fall, sample on rise, apply at select rise.
// - Serial, both selects low: 8-bit setting frame returning eight fault flags.
// - Daisy chains work with both frame lengths on one select.
module osfc_core (
  input  wire logic       i_core_clk,             // Core clock, 40 MHz
  input  wire logic       i_rst_n,                // Asynchronous reset, active low
  input  wire logic       i_clk_en,               // Freezes all state while low
  input  wire logic       i_sclk,                 // Serial clock from controller
  input  wire logic       i_cs_n,                 // Chip select, active low
  input  wire logic       i_sdi,                  // Serial data in
  input  wire logic       i_serial_mode_select,   // High selects serial mode
  input  wire logic       i_frame_length_select,  // High selects 16-bit frames
  input  wire logic       i_config_frame_select,  // High selects configuration frames
  input  wire logic       i_global_pushpull_force, // High forces all push-pull
  input  wire logic       i_global_openload_enable, // High enables open-load on all high-side channels in serial mode
  input  wire logic       i_check_enable_pin,     // High enables the check byte in serial mode
  input  wire logic [7:0] i_ch_overload,          // Push-pull overload per channel
  input  wire logic [7:0] i_ch_thermal,           // Thermal shutdown per channel
  input  wire logic [7:0] i_ch_openload,          // Open-load sensed per channel
  input  wire logic [7:0] i_ch_level,             // Output above level threshold
  input  wire logic       i_uvlo,                 // Undervoltage lockout present
  output logic            o_sdo,                  // Serial data out
  output logic            o_sdo_oe_n,             // Low while the data out is driven
  output logic            o_check_error_pin,      // Check error indication
  output logic      [7:0] o_output_setting,       // Per-channel output setting
  output logic      [7:0] o_pushpull_mode,        // Per-channel push-pull mode
  output logic      [7:0] o_openload_active       // Per-channel open-load detect on
);

  typedef struct packed {
    logic [23:0]              shreg;
    logic                     sdo;
    logic [4:0]               count;
    osfc_pkg::osfc_frame_type mode;
    logic                     crc_on;
    logic                     sclk_q;
    logic                     cs_q;
    logic [7:0]               setting;
    logic [7:0]               pp_cfg;
    logic [7:0]               ol_cfg;
    logic                     err_pin;
    logic                     err_flag;
  } osfc_core_type;

  osfc_core_type state;
  osfc_core_type next_state;

  logic [8:0]  link_f;
  logic [32:0] stat_f;
  logic        sclk_f;
  logic        cs_f;
  logic        cs_act;
  logic        sdi_f;
  logic        serial_f;
  logic        long_f;
  logic        cfg_f;
  logic        force_f;
  logic        gol_f;
  logic        crc_f;
  logic [7:0]  ovl_f;
  logic [7:0]  thm_f;
  logic [7:0]  opl_f;
  logic [7:0]  lvl_f;
  logic        uvlo_f;

  osfc_sync #(
    .W (osfc_pkg::LINK_SYNC_W)
  ) u_link_sync (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_clk_en   (i_clk_en),
    .i_async    ({i_sclk, ~i_cs_n, i_sdi, i_serial_mode_select, i_frame_length_select,
                  i_config_frame_select, i_global_pushpull_force,
                  i_global_openload_enable, i_check_enable_pin}),
    .o_level    (link_f)
  );

  osfc_sync #(
    .W (osfc_pkg::STAT_SYNC_W)
  ) u_stat_sync (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_clk_en   (i_clk_en),
    .i_async    ({i_ch_overload, i_ch_thermal, i_ch_openload, i_ch_level, i_uvlo}),
    .o_level    (stat_f)
  );

  assign {sclk_f, cs_act, sdi_f, serial_f, long_f, cfg_f, force_f, gol_f, crc_f} = link_f;
  // Select enters inverted so the cleared synchroniser reads as deselected,
  // otherwise a false select fall would follow every reset
  assign cs_f = !cs_act;
  assign {ovl_f, thm_f, opl_f, lvl_f, uvlo_f} = stat_f;

  // Effective channel modes from stored configuration and global pins
  logic [7:0] pp_eff;
  logic [7:0] ol_eff;
  logic [7:0] diag8;
  logic [15:0] diag16;

  always_comb begin
    pp_eff = state.pp_cfg | {osfc_pkg::CH_COUNT{force_f}};
    // Global enable only counts in serial mode
    ol_eff = ~pp_eff & (state.ol_cfg | {osfc_pkg::CH_COUNT{serial_f & gol_f}});
    for (int c = 0; c < osfc_pkg::CH_COUNT; c++) begin
      if (uvlo_f) begin
        diag8[c] = 1'b1;
      end else if (pp_eff[c]) begin
        diag8[c] = ovl_f[c] | thm_f[c];
      end else begin
        // Open load only counts while the high-side switch is off
        diag8[c] = thm_f[c] | (ol_eff[c] & opl_f[c] & ~state.setting[c]);
      end
      // Pairs go out with the highest channel first
      if (uvlo_f) begin
        diag16[2*c+1 -: 2] = 2'b11;
      end else if (diag8[c]) begin
        diag16[2*c+1 -: 2] = 2'b10;
      end else begin
        diag16[2*c+1 -: 2] = {1'b0, lvl_f[c]};
      end
    end
  end

  // Frame selection as seen at the chip select falling edge
  osfc_pkg::osfc_frame_type cap_mode;
  logic                     cap_long;
  logic                     cap_crc;

  always_comb begin
    cap_crc = serial_f & crc_f;
    if (!serial_f) begin
      cap_mode = osfc_pkg::FR_CFG16;
    end else if (long_f && cfg_f) begin
      cap_mode = osfc_pkg::FR_CFG16;
    end else if (long_f) begin
      cap_mode = osfc_pkg::FR_SETCFG16;
    end else if (cfg_f) begin
      cap_mode = osfc_pkg::FR_CFG8;
    end else begin
      cap_mode = osfc_pkg::FR_SET8;
    end
    cap_long = (cap_mode == osfc_pkg::FR_SETCFG16) || (cap_mode == osfc_pkg::FR_CFG16);
  end

  // Outbound check over the diagnostics followed by the error flag
  logic [16:0] tx_crc_in;
  logic [6:0]  tx_crc;

  assign tx_crc_in = cap_long ? {diag16, state.err_flag}
                              : {8'h00, diag8, state.err_flag};

  osfc_crc7 u_tx_crc (
    .i_bits (tx_crc_in),
    .i_long (cap_long),
    .o_crc  (tx_crc)
  );

  // Inbound check over the data followed by the leading one of the check byte
  logic        cur_long;
  logic [16:0] rx_crc_in;
  logic [6:0]  rx_crc;
  logic [15:0] rx_data;
  logic        rx_ok;

  assign cur_long  = (state.mode == osfc_pkg::FR_SETCFG16) || (state.mode == osfc_pkg::FR_CFG16);
  assign rx_crc_in = cur_long ? {state.shreg[23:8], 1'b1}
                              : {8'h00, state.shreg[15:8], 1'b1};
  assign rx_data   = state.crc_on ? state.shreg[23:8] : state.shreg[15:0];

  osfc_crc7 u_rx_crc (
    .i_bits (rx_crc_in),
    .i_long (cur_long),
    .o_crc  (rx_crc)
  );

  assign rx_ok = state.shreg[7] && (rx_crc == state.shreg[6:0]);

  // Frame length in bits for the latched and the capture-time selection
  logic [4:0] cur_len;
  logic [4:0] cap_len;
  logic [23:0] cap_word;

  always_comb begin
    cur_len = (cur_long ? osfc_pkg::LEN_LONG : osfc_pkg::LEN_SHORT)
            + (state.crc_on ? osfc_pkg::LEN_CHECK : 5'h00);
    cap_len = (cap_long ? osfc_pkg::LEN_LONG : osfc_pkg::LEN_SHORT)
            + (cap_crc ? osfc_pkg::LEN_CHECK : 5'h00);
    // Frame sits in the low bits so that the top of it leaves first
    case ({cap_long, cap_crc})
      2'b00:   cap_word = {16'h0000, diag8};
      2'b01:   cap_word = {8'h00, diag8, state.err_flag, tx_crc};
      2'b10:   cap_word = {8'h00, diag16};
      2'b11:   cap_word = {diag16, state.err_flag, tx_crc};
      default: cap_word = 24'h000000;
    endcase
  end

  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;

  assign cs_fall   = state.cs_q && !cs_f;
  assign cs_rise   = !state.cs_q && cs_f;
  assign sclk_rise = !state.sclk_q && sclk_f && !cs_f;

  always_comb begin
    logic [23:0] shifted;
    shifted           = {state.shreg[22:0], sdi_f};
    next_state        = state;
    next_state.sclk_q = sclk_f;
    next_state.cs_q   = cs_f;
    if (cs_fall) begin
      next_state.shreg  = cap_word;
      next_state.mode   = cap_mode;
      next_state.crc_on = cap_crc;
      next_state.count  = 5'h00;
      next_state.sdo    = cap_word[cap_len - 5'h01];
    end else if (sclk_rise) begin
      // Bits beyond our own length pass on to the next device in the chain
      next_state.shreg = shifted;
      // Next bit is put out one core cycle after the synchronised rise, held past the next rise
      next_state.sdo   = shifted[cur_len - 5'h01];
      if (state.count != osfc_pkg::COUNT_MAX) begin
        next_state.count = state.count + 5'h01;
      end
    end
    // Short frames are ignored: a partial frame must not disturb the outputs
    if (cs_rise && (state.count >= cur_len)) begin
      if (state.crc_on && !rx_ok) begin
        next_state.err_pin  = 1'b1;
        next_state.err_flag = 1'b1;
      end else begin
        if (state.crc_on) begin
          next_state.err_pin = 1'b0;
        end
        next_state.err_flag = 1'b0;
        case (state.mode)
          osfc_pkg::FR_SET8: begin
            next_state.setting = rx_data[7:0];
          end
          osfc_pkg::FR_CFG8: begin
            next_state.pp_cfg = rx_data[7:0];
          end
          osfc_pkg::FR_SETCFG16: begin
            next_state.setting = rx_data[15:8];
            next_state.pp_cfg  = rx_data[7:0];
          end
          osfc_pkg::FR_CFG16: begin
            for (int c = 0; c < osfc_pkg::CH_COUNT; c++) begin
              next_state.ol_cfg[c] = rx_data[2*c+1];
              next_state.pp_cfg[c] = rx_data[2*c];
            end
          end
          default: begin
            next_state.setting = state.setting;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state         <= '0;
      state.mode    <= osfc_pkg::FR_SET8;
      state.sclk_q  <= 1'b0;
      state.cs_q    <= 1'b1;
      state.setting <= osfc_pkg::SETTING_RESET;
      state.pp_cfg  <= osfc_pkg::CFG_RESET;
      state.ol_cfg  <= osfc_pkg::CFG_RESET;
    end else if (i_clk_en) begin
      state <= next_state;
    end
  end

  assign o_sdo             = state.sdo;
  assign o_sdo_oe_n        = state.cs_q;
  assign o_check_error_pin = state.err_pin;
  assign o_output_setting  = state.setting;
  assign o_pushpull_mode   = pp_eff;
  assign o_openload_active = ol_eff;

endmodule

// ==== osfc_core_checker.sv ====
// Port-level timing checks for the serial frame core
module osfc_core_checker (
  input wire logic       i_core_clk,              // Core clock
  input wire logic       i_rst_n,                 // Reset, active low
  input wire logic       i_cs_n,                  // Chip select
  input wire logic       i_serial_mode_select,    // Serial mode
  input wire logic       i_check_enable_pin,      // Check enable
  input wire logic       i_global_pushpull_force, // Force push-pull
  input wire logic       o_sdo_oe_n,              // Data out release
  input wire logic       o_check_error_pin,       // Error pin
  input wire logic [7:0] o_output_setting,        // Settings
  input wire logic [7:0] o_pushpull_mode,         // Push-pull modes
  input wire logic [7:0] o_openload_active        // Open-load detect
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  // Windows allow for the three-stage input synchroniser
  property p_release; $rose(i_cs_n) |-> ##[3:8] o_sdo_oe_n; endproperty
  a_release: assert property (p_release)
    else $error("data out not released after select rise");
  property p_idle; i_cs_n [*8] |-> o_sdo_oe_n; endproperty
  a_idle: assert property (p_idle)
    else $error("data out driven while deselected");
  property p_drive; $fell(i_cs_n) |-> ##[3:8] !o_sdo_oe_n; endproperty
  a_drive: assert property (p_drive)
    else $error("data out not driven after select fall");
  property p_apply; !$stable(o_output_setting) |-> $past(i_cs_n, 4); endproperty
  a_apply: assert property (p_apply)
    else $error("settings changed inside a frame");
  property p_force; i_global_pushpull_force [*8] |-> o_pushpull_mode == 8'hff; endproperty
  a_force: assert property (p_force)
    else $error("forced push-pull not applied");
  property p_ol_hs; (o_openload_active & o_pushpull_mode) == 8'h00; endproperty
  a_ol_hs: assert property (p_ol_hs)
    else $error("open-load active on push-pull channel");
  property p_err_rise;
    $rose(o_check_error_pin) |-> $past(i_cs_n, 4) && i_check_enable_pin && i_serial_mode_select;
  endproperty
  a_err_rise: assert property (p_err_rise)
    else $error("error pin raised without checked frame end");
  property p_err_hold;
    $rose(o_check_error_pin) |-> $stable(o_output_setting) && $stable(o_pushpull_mode);
  endproperty
  a_err_hold: assert property (p_err_hold)
    else $error("failed frame changed outputs");
  property p_err_clear; $fell(o_check_error_pin) |-> $past(i_cs_n, 4) && i_check_enable_pin;
  endproperty
  a_err_clear: assert property (p_err_clear)
    else $error("error pin cleared outside a checked frame end");

  c_err_set: cover property ($rose(o_check_error_pin));
  c_err_clr: cover property ($fell(o_check_error_pin));
  c_apply: cover property (!$stable(o_output_setting));
endmodule

bind osfc_core osfc_core_checker chk (
  .i_core_clk, .i_rst_n, .i_cs_n, .i_serial_mode_select, .i_check_enable_pin,
  .i_global_pushpull_force, .o_sdo_oe_n, .o_check_error_pin, .o_output_setting,
  .o_pushpull_mode, .o_openload_active
);

// ==== osfc_spi_host.sv ====
// Mode 0 serial controller model driving frames into the switch
module osfc_spi_host (
  input  wire logic i_core_clk, // Core clock
  input  wire logic i_sdo,      // Data line level
  output logic      o_sclk,     // Serial clock
  output logic      o_cs_n,     // Chip select
  output logic      o_sdi       // Data to device
);
  timeunit 1ns;
  timeprecision 1ps;
  int half = 4;

  initial begin
    o_sclk = 1'h0;
    o_cs_n = 1'h1;
    o_sdi  = 1'h0;
  end

  // Clock stands low between frames; data changes on falling clock edges and at both select edges
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = '0;
    @(posedge i_core_clk);
    o_cs_n <= 1'h0;
    o_sdi  <= tx[n-1];
    repeat (8) @(posedge i_core_clk);
    for (int i = n - 1; i >= 0; i--) begin
      o_sclk <= 1'h1;
      rx = {rx[30:0], i_sdo};
      repeat (half) @(posedge i_core_clk);
      o_sclk <= 1'h0;
      if (i > 0) o_sdi <= tx[i-1];
      repeat (half) @(posedge i_core_clk);
    end
    o_cs_n <= 1'h1;
    // Released data line must not keep a stale value
    o_sdi  <= ~o_sdi;
    repeat (12) @(posedge i_core_clk);
  endtask
endmodule

// ==== tb_top.sv ====
// Testbench for the serial frame core
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk = 1'h0;
  logic i_rst_n, i_clk_en, i_sclk, i_cs_n, i_sdi, i_serial_mode_select;
  logic i_frame_length_select, i_config_frame_select, i_global_pushpull_force;
  logic i_global_openload_enable, i_check_enable_pin, i_uvlo;
  logic [7:0] i_ch_overload, i_ch_thermal, i_ch_openload, i_ch_level;
  logic o_sdo, o_sdo_oe_n, o_check_error_pin;
  logic [7:0] o_output_setting, o_pushpull_mode, o_openload_active;
  logic [31:0] rx;
  int errors = 0;
  int samples_checked = 0;
  // Weak pull-down holds the shared line low when released
  wire logic sdo_line = o_sdo_oe_n ? 1'h0 : o_sdo;

  always #12.5 i_core_clk = ~i_core_clk;

  osfc_core uut (
    .i_core_clk, .i_rst_n, .i_clk_en, .i_sclk, .i_cs_n, .i_sdi, .i_serial_mode_select,
    .i_frame_length_select, .i_config_frame_select, .i_global_pushpull_force,
    .i_global_openload_enable, .i_check_enable_pin, .i_ch_overload, .i_ch_thermal,
    .i_ch_openload, .i_ch_level, .i_uvlo, .o_sdo, .o_sdo_oe_n, .o_check_error_pin,
    .o_output_setting, .o_pushpull_mode, .o_openload_active
  );
  osfc_spi_host host (
    .i_core_clk, .i_sdo(sdo_line), .o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_sdi(i_sdi)
  );

  task automatic end_of_test;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // Mode pins {serial, length, config, check} change a cycle before select falls
  task automatic go(input logic [3:0] m, input logic [31:0] tx, input int n);
    @(posedge i_core_clk);
    {i_serial_mode_select, i_frame_length_select, i_config_frame_select,
     i_check_enable_pin} <= m;
    host.xfer(tx, n, rx);
  endtask

  function automatic logic [7:0] f8(logic [7:0] pp, logic [7:0] ola, logic [7:0] set);
    return ((i_ch_overload | i_ch_thermal) & pp) | (i_ch_thermal & ~pp)
           | (ola & ~pp & i_ch_openload & ~set);
  endfunction

  function automatic logic [15:0] pair(logic [7:0] f);
    logic [15:0] r;
    for (int i = 0; i < 8; i++) begin
      r[2*i+1] = f[i];
      r[2*i] = i_ch_level[i] & ~f[i];
    end
    return r;
  endfunction

  function automatic logic [6:0] crc7(logic [16:0] d, int n);
    logic [6:0] c;
    c = osfc_pkg::CRC_INIT;
    for (int i = n - 1; i >= 0; i--) begin
      c = {c[5:0], 1'h0} ^ ((c[6] ^ d[i]) ? osfc_pkg::CRC_POLY : 7'h00);
    end
    return c;
  endfunction

  function automatic logic [15:0] cb(logic [7:0] d);
    return {d, 1'h1, crc7({d, 1'h1}, 9)};
  endfunction

  initial begin
    repeat (40000) @(posedge i_core_clk);
    errors++;
    end_of_test();
  end

  initial begin
    {i_rst_n, i_clk_en, i_global_pushpull_force, i_global_openload_enable, i_uvlo} = 5'h08;
    {i_serial_mode_select, i_frame_length_select, i_config_frame_select} = 3'h4;
    i_check_enable_pin = 1'h0;
    {i_ch_overload, i_ch_thermal, i_ch_openload, i_ch_level} = 32'h03814455;
    repeat (12) @(posedge i_core_clk);
    i_rst_n <= 1'h1;
    repeat (10) @(posedge i_core_clk);
    chk("oe idle", o_sdo_oe_n, 1'h1);
    go(4'h8, 32'h115a, 16);
    chk("chain set", o_output_setting, 8'h5a);
    chk("chain pass", rx[7:0], 8'h11);
    chk("fault hs", rx[15:8], f8(8'h00, 8'h00, 8'h00));
    go(4'ha, 32'h0f, 8);
    chk("mode8", o_pushpull_mode, 8'h0f);
    chk("set kept", o_output_setting, 8'h5a);
    chk("fault8", rx[7:0], f8(8'h00, 8'h00, 8'h5a));
    go(4'hc, 32'h3cf0, 16);
    chk("set16", o_output_setting, 8'h3c);
    chk("mode16", o_pushpull_mode, 8'hf0);
    chk("diag16", rx[15:0], pair(f8(8'h0f, 8'h00, 8'h5a)));
    go(4'he, 32'he4e4, 16);
    chk("cfg pp", o_pushpull_mode, 8'haa);
    chk("cfg ol", o_openload_active, 8'h44);
    chk("cfg set", o_output_setting, 8'h3c);
    chk("cfg diag", rx[15:0], pair(f8(8'hf0, 8'h00, 8'h3c)));
    @(posedge i_core_clk);
    i_global_openload_enable <= 1'h1;
    repeat (8) @(posedge i_core_clk);
    chk("ol global", o_openload_active, 8'h55);
    go(4'h8, 32'h00, 8);
    chk("fault ol", rx[7:0], f8(8'haa, 8'h55, 8'h3c));
    chk("set zero", o_output_setting, 8'h00);
    @(posedge i_core_clk);
    i_uvlo <= 1'h1;
    go(4'h8, 32'h00, 8);
    chk("uvlo8", rx[7:0], 8'hff);
    go(4'he, 32'he4e4, 16);
    chk("uvlo16", rx[15:0], 16'hffff);
    @(posedge i_core_clk);
    {i_uvlo, i_global_pushpull_force} <= 2'h1;
    repeat (8) @(posedge i_core_clk);
    chk("force pp", o_pushpull_mode, 8'hff);
    chk("force ol", o_openload_active, 8'h00);
    @(posedge i_core_clk);
    {i_global_pushpull_force, i_global_openload_enable} <= 2'h0;
    repeat (8) @(posedge i_core_clk);
    go(4'h9, cb(8'h96), 16);
    chk("crc set", o_output_setting, 8'h96);
    chk("crc diag", rx[15:8], f8(8'haa, 8'h44, 8'h00));
    chk("crc out", rx[7:0], {1'h0, crc7({f8(8'haa, 8'h44, 8'h00), 1'h0}, 9)});
    go(4'h9, cb(8'h33) ^ 16'h0001, 16);
    chk("bad kept", o_output_setting, 8'h96);
    chk("err pin", o_check_error_pin, 1'h1);
    go(4'h9, cb(8'h00), 16);
    chk("err flag", rx[7:0], {1'h1, crc7({f8(8'haa, 8'h44, 8'h96), 1'h1}, 9)});
    chk("err clear", o_check_error_pin, 1'h0);
    chk("crc set2", o_output_setting, 8'h00);
    // Clock enable low must freeze the synchronised global pins as well
    @(posedge i_core_clk);
    {i_clk_en, i_global_openload_enable} <= 2'h1;
    repeat (8) @(posedge i_core_clk);
    chk("ol frozen", o_openload_active, 8'h44);
    i_clk_en <= 1'h1;
    repeat (8) @(posedge i_core_clk);
    chk("ol thaw", o_openload_active, 8'h55);
    // Parallel mode: always the long configuration frame, check pin ignored
    go(4'h1, 32'h1b1b, 16);
    chk("par pp", o_pushpull_mode, 8'h55);
    chk("par ol", o_openload_active, 8'h22);
    chk("par diag", rx[15:0], pair(f8(8'haa, 8'h44, 8'h00)));
    end_of_test();
  end
endmodule
